/* rtl/timer_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "timer_consts.svh"


module timer_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_timer_clock_pin,
  input wire logic secondary_osc_clock,
  output logic timer_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] timer_control_q, count_register_q, period_register_q;
  logic [31:0] count_sync1_q, count_sync2_q, pend_q;
  logic timer_irq_flag_q, timer_irq_enable_q, timer_irq_q;
  logic ext_prev_q, gate_prev_q, on_prev_q;
  logic [1:0] start_cnt_q;
  timer_pkg::wsync_e wsync_q;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge shared by the control, count and period registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_CONTROL) || (a == `OFF_COUNT) || (a == `OFF_PERIOD) ||
             (a == `OFF_IRQ);
  endfunction : mapped

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire on = timer_control_q[`BIT_ON];
  wire clock_source_select = timer_control_q[`BIT_CLOCK_SOURCE];
  wire ext_clock_sync_enable = timer_control_q[`BIT_EXT_SYNC];
  wire pair_mode_enable = timer_control_q[`BIT_PAIR_MODE];
  wire gate_enable = timer_control_q[`BIT_GATE];
  wire secondary_osc_select = timer_control_q[`BIT_OSC_SELECT];
  wire async_write_disable = timer_control_q[`BIT_WDIS];
  wire [1:0] prescale_select = timer_control_q[`BIT_PSC_HI:`BIT_PSC_LO];
  wire timer_pkg::mode_e mode = !clock_source_select ?
      (gate_enable ? timer_pkg::MODE_GATED : timer_pkg::MODE_INTERNAL) :
      (ext_clock_sync_enable ? timer_pkg::MODE_EXT_SYNC : timer_pkg::MODE_ASYNC);
  wire async_mode = (mode == timer_pkg::MODE_ASYNC);
  wire ext_mode = clock_source_select;

  // ----------------------------------------
  // Timer clock source and edges
  // ----------------------------------------
  // oscillator as source
  wire ext_in = secondary_osc_select ? secondary_osc_clock : ext_timer_clock_pin;
  wire ext_rise = ext_in && !ext_prev_q;
  wire gate_fall = !ext_timer_clock_pin && gate_prev_q;
  wire started = (start_cnt_q == `START_EDGES);

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid && awready_q;
  wire w_hs = s_axi_wvalid && wready_q;
  wire ar_hs = s_axi_arvalid && arready_q;
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire wr_control = do_write && (awaddr_q == `OFF_CONTROL);
  wire wr_count = do_write && (awaddr_q == `OFF_COUNT);
  wire wr_period = do_write && (awaddr_q == `OFF_PERIOD);
  wire wr_irq = do_write && (awaddr_q == `OFF_IRQ);
  wire [31:0] count_wval = merge(count_register_q, wdata_q, wstrb_q);
  // Protected writes overlapping a pending one are dropped
  wire wsync_busy = (wsync_q != timer_pkg::WSYNC_IDLE);
  wire wr_count_async = wr_count && on && async_mode && !(wsync_busy && async_write_disable);
  wire wr_count_now = wr_count && !(on && async_mode);
  wire wsync_land = (wsync_q == timer_pkg::WSYNC_SECOND) && ext_rise;

  // ----------------------------------------
  // Count tick and match
  // ----------------------------------------
  // pair mode width
  wire [31:0] eff_period = pair_mode_enable ? period_register_q :
                           {16'h0000, period_register_q[15:0]};
  wire [31:0] count_inc = pair_mode_enable ? count_register_q + 32'h0000_0001 :
                          {16'h0000, count_register_q[15:0] + 16'h0001};
  wire base_tick = (mode == timer_pkg::MODE_INTERNAL) ||
                   ((mode == timer_pkg::MODE_GATED) && ext_timer_clock_pin) ||
                   (ext_mode && ext_rise && started);
  wire psc_clear = !on || wr_count || wsync_land;
  logic psc_tick;

  timer_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(psc_clear),
    .tick_in(on && base_tick),
    .prescale_select(prescale_select),
    .tick_out(psc_tick)
  );

  wire match = psc_tick && (count_register_q == eff_period);
  wire timer_event = (match && (mode != timer_pkg::MODE_GATED)) ||
                     (on && (mode == timer_pkg::MODE_GATED) && gate_fall);

  // ----------------------------------------
  // AXI write channels
  // ----------------------------------------
  // Address and data taken in either order, answered once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  // lagged count read
  wire [31:0] count_view = async_mode ? count_sync2_q : count_register_q;
  wire wip_view = async_mode && wsync_busy;
  wire [31:0] control_view = timer_control_q | {20'h00000, wip_view, 11'h000};
  wire [31:0] irq_view = {30'h0000_0000, timer_irq_enable_q, timer_irq_flag_q};
  wire [31:0] read_mux = (s_axi_araddr == `OFF_CONTROL) ? control_view :
                         (s_axi_araddr == `OFF_COUNT) ? count_view :
                         (s_axi_araddr == `OFF_PERIOD) ? period_register_q :
                         (s_axi_araddr == `OFF_IRQ) ? irq_view : 32'h0000_0000;

  // One read in flight; data registered on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= read_mux;
      rresp_q <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control, period and interrupt registers
  // ----------------------------------------
  // Software owns these; the flag is write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_q <= `RST_CONTROL;
      period_register_q <= `RST_PERIOD;
      timer_irq_enable_q <= 1'b0;
      timer_irq_flag_q <= 1'b0;
      timer_irq_q <= 1'b0;
    end else begin
      if (wr_control) begin
        timer_control_q <= merge(timer_control_q, wdata_q, wstrb_q) & `CONTROL_WR_MASK;
      end
      if (wr_period) begin
        period_register_q <= merge(period_register_q, wdata_q, wstrb_q);
      end
      if (wr_irq && wstrb_q[0]) begin
        timer_irq_enable_q <= wdata_q[`BIT_IRQ_ENABLE];
      end
      if (timer_event) begin
        timer_irq_flag_q <= 1'b1;
      end else if (wr_irq && wstrb_q[0] && wdata_q[`BIT_IRQ_FLAG]) begin
        timer_irq_flag_q <= 1'b0;
      end
      timer_irq_q <= timer_irq_flag_q && timer_irq_enable_q;
    end
  end

  // ----------------------------------------
  // Edge history and start delay
  // ----------------------------------------
  // Start count restarts on every enable so stale edges never count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b0;
      gate_prev_q <= 1'b0;
      on_prev_q <= 1'b0;
      start_cnt_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_in;
      gate_prev_q <= ext_timer_clock_pin;
      on_prev_q <= on;
      if (!on || !on_prev_q) begin
        start_cnt_q <= 2'h0;
      end else if (ext_rise && !started) begin
        start_cnt_q <= start_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Count write synchroniser
  // ----------------------------------------
  // Legacy mode lets a new write replace the pending value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wsync_q <= timer_pkg::WSYNC_IDLE;
      pend_q <= `RST_COUNT;
    end else if (wr_count_async) begin
      wsync_q <= timer_pkg::WSYNC_FIRST;
      pend_q <= count_wval;
    end else if (!(on && async_mode)) begin
      wsync_q <= timer_pkg::WSYNC_IDLE;
    end else if (ext_rise) begin
      case (wsync_q)
        timer_pkg::WSYNC_FIRST: wsync_q <= timer_pkg::WSYNC_SECOND;
        timer_pkg::WSYNC_SECOND: wsync_q <= timer_pkg::WSYNC_IDLE;
        default: wsync_q <= timer_pkg::WSYNC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Counter and read synchroniser
  // ----------------------------------------
  // A landing write masks the increment of that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_register_q <= `RST_COUNT;
      count_sync1_q <= `RST_COUNT;
      count_sync2_q <= `RST_COUNT;
    end else begin
      if (wr_count_now) begin
        count_register_q <= count_wval;
      end else if (wsync_land) begin
        count_register_q <= pend_q;
      end else if (match) begin
        count_register_q <= 32'h0000_0000;
      end else if (psc_tick) begin
        count_register_q <= count_inc;
      end
      count_sync1_q <= count_register_q;
      count_sync2_q <= count_sync1_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign timer_irq = timer_irq_q;

endmodule : timer_top

/* common/timer_consts.svh */
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_CONTROL 8'h00
`define OFF_COUNT 8'h04
`define OFF_PERIOD 8'h08
`define OFF_IRQ 8'h0C

// ----------------------------------------
// Control and interrupt register field positions
// ----------------------------------------
`define BIT_ON 15
`define BIT_CLOCK_SOURCE 1
`define BIT_EXT_SYNC 2
`define BIT_PAIR_MODE 3
`define BIT_PSC_LO 4
`define BIT_PSC_HI 5
`define BIT_GATE 7
`define BIT_OSC_SELECT 8
`define BIT_WIP 11
`define BIT_WDIS 12
`define CONTROL_WR_MASK 32'h0000_91BE
`define BIT_IRQ_FLAG 0
`define BIT_IRQ_ENABLE 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL 32'h0000_0000
`define RST_COUNT 32'h0000_0000
`define RST_PERIOD 32'hFFFF_FFFF

// ----------------------------------------
// Timing counts, prescale limits and bus response codes
// ----------------------------------------
`define START_EDGES 2'h2
`define PSC_LIMIT_1 8'h00
`define PSC_LIMIT_8 8'h07
`define PSC_LIMIT_64 8'h3F
`define PSC_LIMIT_256 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* common/timer_pkg.sv */
package timer_pkg;

  // Counting mode decoded from the control register
  typedef enum logic [1:0] {
    MODE_INTERNAL = 2'b00,
    MODE_GATED = 2'b01,
    MODE_EXT_SYNC = 2'b10,
    MODE_ASYNC = 2'b11
  } mode_e;

  // Count write synchroniser progress in external clock edges
  typedef enum logic [1:0] {
    WSYNC_IDLE = 2'b00,
    WSYNC_FIRST = 2'b01,
    WSYNC_SECOND = 2'b10
  } wsync_e;

endpackage : timer_pkg

/* rtl/timer_prescaler.sv */
`timescale 1ns/1ps
`include "timer_consts.svh"

module timer_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] prescale_select,
  output logic tick_out
);

  logic [7:0] cnt_q;
  logic [7:0] limit;

  // Ratio decode: 1:1, 1:8, 1:64, 1:256
  function automatic logic [7:0] ratio_limit(input logic [1:0] sel);
    case (sel)
      2'b00: ratio_limit = `PSC_LIMIT_1;
      2'b01: ratio_limit = `PSC_LIMIT_8;
      2'b10: ratio_limit = `PSC_LIMIT_64;
      default: ratio_limit = `PSC_LIMIT_256;
    endcase
  endfunction : ratio_limit

  assign limit = ratio_limit(prescale_select);
  assign tick_out = tick_in && !clear && (cnt_q >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || tick_out) begin
      cnt_q <= 8'h00;
    end else if (tick_in) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

endmodule : timer_prescaler

/* verif/ext_clock_model.sv */
`timescale 1ns/1ps

module ext_clock_model (
  input wire logic aclk,
  input wire logic start,
  input wire logic use_osc,
  input wire logic [11:0] edges,
  output logic ext_timer_clock_pin,
  output logic secondary_osc_clock,
  output logic busy
);
  // ----------------------------------------
  // Burst clock source
  // ----------------------------------------
  logic [11:0] left_q = 12'h000;
  logic [1:0] phase_q = 2'h0;
  logic level_q = 1'b0;

  // Three aclk high, three low; stands low between bursts
  // Plain always so the declaration initialisers stay legal
  always @(posedge aclk) begin
    if (start) begin
      left_q <= edges;
      phase_q <= 2'h0;
    end else if (left_q != 12'h000) begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      if (phase_q == 2'h2) begin
        level_q <= !level_q;
        if (level_q) left_q <= left_q - 12'h001;
      end
    end
  end

  assign ext_timer_clock_pin = level_q && !use_osc;
  assign secondary_osc_clock = level_q && use_osc;
  assign busy = start || (left_q != 12'h000);
endmodule : ext_clock_model

/* verif/timer_top_asserts.sv */
`timescale 1ns/1ps

module timer_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_irq
);
  // ----------------------------------------
  // Bus and interrupt checks
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready high after address taken");
  a_w_taken: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("wready high after data taken");
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after request");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after address");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed after data");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("illegal write response code");
  // Interrupt only ends through a register write
  a_irq_drop: assert property ($fell(timer_irq) |-> $past(s_axi_bvalid))
    else $error("interrupt dropped without a write");
endmodule : timer_top_chk

bind timer_top timer_top_chk chk_i (.*);

/* verif/gated_and_async_timer_counter_tb.sv */
`timescale 1ns/1ps

module gated_and_async_timer_counter_tb;
  // ----------------------------------------
  // Signals, design and clock source
  // ----------------------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_irq, ext_timer_clock_pin, secondary_osc_clock;
  logic start, use_osc, busy;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] edges;
  int num_errors, checks_done;

  timer_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_timer_clock_pin,
    .secondary_osc_clock, .timer_irq);
  ext_clock_model src (.aclk, .start, .use_osc, .edges, .ext_timer_clock_pin,
    .secondary_osc_clock, .busy);

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Ready is sampled at the edge; valids drop right after their own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    check({29'h0, s_axi_bvalid, s_axi_bresp}, 32'h4);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    check({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
    check(s_axi_rdata, exp);
  endtask : rd_chk

  // Burst of n source clocks, then settle past the read lag
  task automatic pulse(input logic [11:0] n, input logic osc);
    start <= 1'b1;
    edges <= n;
    use_osc <= osc;
    @(posedge aclk);
    start <= 1'b0;
    for (int i = 0; i < 8000 && busy; i++) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : pulse

  task automatic cfg(input logic [31:0] ctl, input logic [31:0] cnt, input logic [31:0] per);
    wr(8'h00, 32'h0);
    wr(8'h04, cnt);
    wr(8'h00, ctl & 32'hFFFF_7FFF);
    wr(8'h08, per);
    wr(8'h00, ctl);
  endtask : cfg

  task automatic t_reset;
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h04, 32'h0, 2'h0);
    rd_chk(8'h08, 32'hFFFF_FFFF, 2'h0);
    rd_chk(8'h10, 32'h0, 2'h2);
  endtask : t_reset

  task automatic t_async_match;
    cfg(32'h8002, 32'h0, 32'h5);
    pulse(12'd11, 1'b0);
    rd_chk(8'h04, 32'h3, 2'h0);
    rd_chk(8'h0C, 32'h1, 2'h0);
    wr(8'h0C, 32'h2);
    repeat (2) @(posedge aclk);
    check({31'h0, timer_irq}, 32'h1);
    wr(8'h0C, 32'h3);
    repeat (2) @(posedge aclk);
    check({31'h0, timer_irq}, 32'h0);
    cfg(32'h8002, 32'h0, 32'h0);
    pulse(12'd6, 1'b0);
    rd_chk(8'h04, 32'h0, 2'h0);
  endtask : t_async_match

  task automatic t_prescale;
    logic [11:0] r;
    for (int k = 0; k < 4; k++) begin
      r = (k == 3) ? 12'h100 : (12'h001 << (3 * k));
      cfg(32'h8002 | (k << 4), 32'h0, 32'hFFFF);
      pulse(12'd2 + 2 * r + r / 2, 1'b0);
      rd_chk(8'h04, 32'h2, 2'h0);
    end
  endtask : t_prescale

  task automatic t_write_sync;
    cfg(32'h8002, 32'h0, 32'hFFFF);
    pulse(12'd2, 1'b0);
    wr(8'h04, 32'h40);
    rd_chk(8'h00, 32'h8802, 2'h0);
    pulse(12'd2, 1'b0);
    rd_chk(8'h04, 32'h40, 2'h0);
    rd_chk(8'h00, 32'h8002, 2'h0);
    cfg(32'h9002, 32'h0, 32'hFFFF);
    pulse(12'd2, 1'b0);
    wr(8'h04, 32'h50);
    wr(8'h04, 32'h60);
    pulse(12'd2, 1'b0);
    rd_chk(8'h04, 32'h50, 2'h0);
    cfg(32'h9006, 32'h0, 32'hFFFF);
    wr(8'h04, 32'h70);
    rd_chk(8'h00, 32'h9006, 2'h0);
    rd_chk(8'h04, 32'h70, 2'h0);
  endtask : t_write_sync

  task automatic t_osc_gate;
    cfg(32'h8102, 32'h0, 32'hFFFF);
    pulse(12'd5, 1'b1);
    rd_chk(8'h04, 32'h3, 2'h0);
    pulse(12'd4, 1'b0);
    rd_chk(8'h04, 32'h3, 2'h0);
    wr(8'h0C, 32'h1);
    cfg(32'h8088, 32'h0, 32'hFFFF);
    pulse(12'd1, 1'b0);
    rd_chk(8'h0C, 32'h1, 2'h0);
    rd_chk(8'h04, 32'h3, 2'h0);
  endtask : t_osc_gate

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, start, use_osc} = 6'h00;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, edges} = 60'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_async_match;
    t_prescale;
    t_write_sync;
    t_osc_gate;
    close_out;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    close_out;
  end
endmodule : gated_and_async_timer_counter_tb
